// ==== lsr_indicator.sv ====
`default_nettype none
module lsr_indicator
	import lsr_pkg::*;
#(
	parameter logic [DIV_W-1:0] FLASH_STEP_CYC = FLASH_STEP_CYC_DEF
) (
	// Clock and reset
	input  wire logic       MCLK_I,
	input  wire logic       RESET_I,
	// Configuration and cascade pins
	input  wire lsr_cfg_t   CFG_PINS_I,
	// Scanner results and events, same clock
	input  wire lsr_beams_t BEAMS_I,
	input  wire logic       LOCKOUT_I,
	input  wire logic [7:0] FAULT_CODE_I,
	input  wire logic       RESET_REQ_I,
	// Indicators and outputs
	output lsr_lamps_t      LAMPS_O,
	output lsr_state_t      STATE_O
);

	typedef struct packed {
		lsr_state_t        st;
		logic [DIV_W-1:0]  div;
		logic [STEP_W-1:0] step;
		logic [PWR_W-1:0]  pwr;
		logic              scan_prev;
		logic [SHOW_W-1:0] show;
		lsr_lamps_t        out;
	} lsr_core_t;

	lsr_core_t r;
	lsr_core_t next_r;
	lsr_cfg_t  cfg;

	// Pins pass two flip-flops first
	lsr_sync2 #(
		.W($bits(lsr_cfg_t))
	) u_sync (
		.clk_i(MCLK_I),
		.rst_i(RESET_I),
		.d_i  (CFG_PINS_I),
		.q_o  (cfg)
	);

	logic tick;
	logic all_clear;
	logic single_fl;
	logic double_fl;
	logic steady_fl;
	logic outputs_on;

	// Flash phases shared by every lamp
	always_comb begin
		tick      = (r.div == FLASH_STEP_CYC - DIV_W'(1));
		single_fl = (r.step[2:1] == 2'b00);
		double_fl = !r.step[2] && !r.step[0];
		steady_fl = r.step[0];
		all_clear = !BEAMS_I.beam1_blocked && (BEAMS_I.zone_blocked == ZONE_NONE);
	end

	// Outputs are on only in run with the field and cascade clear
	always_comb begin
		outputs_on = (r.st == ST_RUN) && all_clear && !cfg.cascade_stop_input;
	end

	// Next state, divider and indicator image
	always_comb begin
		next_r = r;
		if (tick) begin
			next_r.div  = '0;
			next_r.step = r.step + STEP_W'(1);
		end else begin
			next_r.div = r.div + DIV_W'(1);
		end

		next_r.scan_prev = cfg.scan_code;
		if (r.st != ST_PWRUP && cfg.scan_code != r.scan_prev) begin
			next_r.show = SCAN_SHOW_STEPS;
		end else if (tick && r.show != '0) begin
			next_r.show = r.show - SHOW_W'(1);
		end

		// Operating state
		case (r.st)
			ST_PWRUP: begin
				if (tick) begin
					next_r.pwr = r.pwr + PWR_W'(1);
				end
				if (tick && r.pwr == PWRUP_STEPS - PWR_W'(1)) begin
					next_r.st = ST_ALIGN;
				end
			end
			ST_ALIGN: begin
				if (all_clear && (!cfg.latch_cfg || RESET_REQ_I)) begin
					next_r.st = ST_RUN;
				end
			end
			ST_RUN: begin
				if (cfg.latch_cfg && !all_clear) begin
					next_r.st = ST_LATCHED;
				end
			end
			ST_LATCHED: begin
				if (all_clear && RESET_REQ_I) begin
					next_r.st = ST_RUN;
				end
			end
			ST_LOCKOUT: begin
				if (!LOCKOUT_I && RESET_REQ_I) begin
					next_r.st = ST_ALIGN;
				end
			end
			default: begin
				next_r.st = ST_LOCKOUT;
			end
		endcase
		if (LOCKOUT_I) begin
			next_r.st = ST_LOCKOUT;
		end

		// Indicator defaults for the running states
		next_r.out.safety_switching_outputs = outputs_on;
		next_r.out.posts                    = cfg.cascade_stop_input;
		next_r.out.disp_value               = BEAMS_I.blocked_count;
		if (outputs_on) begin
			next_r.out.status = (cfg.red_res && !steady_fl) ? LAMP_OFF : LAMP_GREEN;
		end else begin
			next_r.out.status = LAMP_RED;
		end
		if (BEAMS_I.beam1_blocked) begin
			next_r.out.zone_red   = ZONE_FIRST;
			next_r.out.zone_green = ZONE_NONE;
		end else begin
			next_r.out.zone_red   = BEAMS_I.zone_blocked;
			next_r.out.zone_green = ~BEAMS_I.zone_blocked;
		end
		if (BEAMS_I.beam1_blocked) begin
			next_r.out.disp       = DISP_SYNC;
			next_r.out.disp_value = cfg.latch_cfg ? CODE_SYNC_LATCH : CODE_SYNC_TRIP;
		end else if (!all_clear) begin
			next_r.out.disp = DISP_COUNT;
		end else if (r.st == ST_ALIGN) begin
			next_r.out.disp = DISP_BLANK;
		end else begin
			next_r.out.disp = cfg.latch_cfg ? DISP_LATCH : DISP_TRIP;
		end
		if (r.show != '0) begin
			next_r.out.disp       = DISP_SCAN;
			next_r.out.disp_value = {7'h00, cfg.scan_code};
		end

		case (r.st)
			ST_PWRUP: begin
				next_r.out.reset_lamp = 1'b0;
				next_r.out.status     = single_fl ? LAMP_RED : LAMP_OFF;
				next_r.out.zone_red   = single_fl ? ZONE_ALL : ZONE_NONE;
				next_r.out.zone_green = ZONE_NONE;
				next_r.out.disp       = (r.step[2] == 1'b0) ? DISP_SCAN : DISP_BLANK;
				next_r.out.disp_value = {7'h00, cfg.scan_code};
			end
			ST_ALIGN: begin
				next_r.out.reset_lamp = cfg.latch_cfg && all_clear && double_fl;
			end
			ST_RUN: begin
				next_r.out.reset_lamp = 1'b1;
			end
			ST_LATCHED: begin
				next_r.out.reset_lamp = all_clear ? single_fl : 1'b1;
			end
			default: begin
				next_r.out.reset_lamp = 1'b0;
				next_r.out.status     = steady_fl ? LAMP_RED : LAMP_OFF;
				next_r.out.zone_red   = ZONE_NONE;
				next_r.out.zone_green = ZONE_NONE;
				next_r.out.disp       = DISP_FAULT;
				next_r.out.disp_value = FAULT_CODE_I;
			end
		endcase
	end

	// State register
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			r     <= '0;
			r.st  <= ST_PWRUP;
			r.out <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign LAMPS_O = r.out;
	assign STATE_O = r.st;

	// Lockout darkens outputs, reset lamp and zones, flashes red and shows the fault code
	AST_LOCKOUT_LAMPS: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		r.st == ST_LOCKOUT |=> !r.out.safety_switching_outputs && !r.out.reset_lamp
			&& r.out.zone_red == ZONE_NONE && r.out.zone_green == ZONE_NONE && r.out.disp == DISP_FAULT)
		else $error("Lockout indication wrong");

	// Outputs on always shows green or its flash gap, never red
	AST_ON_NOT_RED: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		r.out.safety_switching_outputs |-> r.out.status != LAMP_RED)
		else $error("Red status while outputs on");

	// Outputs come only from run
	AST_ON_FROM_RUN: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		$rose(r.out.safety_switching_outputs) |-> $past(r.st) == ST_RUN && $past(all_clear))
		else $error("Outputs on outside clear run");

	// First beam blocked keeps only zone one red
	AST_SYNC_ZONES: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		BEAMS_I.beam1_blocked && (r.st == ST_ALIGN || r.st == ST_RUN) && !LOCKOUT_I
			|=> r.out.zone_red == ZONE_FIRST && r.out.zone_green == ZONE_NONE)
		else $error("Zones wrong with first beam blocked");

	// Power-up keeps reset lamp and outputs off
	AST_PWRUP_DARK: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		r.st == ST_PWRUP |=> !r.out.reset_lamp && !r.out.safety_switching_outputs)
		else $error("Power-up lamp or output active");

	// Run lights the reset lamp
	AST_RUN_LAMP: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		r.st == ST_RUN |=> r.out.reset_lamp)
		else $error("Reset lamp dark in run");

	// Latched holds until reset request
	AST_LATCH_HOLD: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		r.st == ST_LATCHED && !RESET_REQ_I && !LOCKOUT_I |=> r.st == ST_LATCHED)
		else $error("Latched left without reset");

	// Cascade stop brackets display and keeps outputs off
	AST_CASCADE: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		cfg.cascade_stop_input && r.st == ST_RUN ##1 cfg.cascade_stop_input
			|-> r.out.posts && !r.out.safety_switching_outputs && r.out.reset_lamp)
		else $error("Cascade stop indication wrong");

	// Trip run with a block stays in run
	AST_TRIP_STAY: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		r.st == ST_RUN && !cfg.latch_cfg && !LOCKOUT_I |=> r.st == ST_RUN)
		else $error("Trip run left run");

	// Power-up lasts the full three scan-code repeats
	AST_PWRUP_LEN: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		r.st == ST_ALIGN && $past(r.st) == ST_PWRUP |-> r.pwr == PWRUP_STEPS && r.step == '0
			&& PWRUP_STEPS == SCAN_REPEATS * PWR_W'(8))
		else $error("Power-up length wrong");

	// Blocked field with beam one clear shows the count and drops outputs
	AST_COUNT_SHOWN: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		!BEAMS_I.beam1_blocked && !all_clear && r.show == '0
			&& (r.st == ST_ALIGN || r.st == ST_RUN || r.st == ST_LATCHED)
			|=> r.out.disp == DISP_COUNT && r.out.disp_value == $past(BEAMS_I.blocked_count)
			&& !r.out.safety_switching_outputs)
		else $error("Blocked count indication wrong");

	// Clear run lights outputs, reset lamp and every zone green
	AST_RUN_CLEAR: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		r.st == ST_RUN && all_clear && !cfg.cascade_stop_input
			|=> r.out.safety_switching_outputs && r.out.reset_lamp && r.out.zone_green == ZONE_ALL)
		else $error("Clear run indication wrong");

	// Latched and clear waits with green zones and a red lamp
	AST_LATCH_CLEAR: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		r.st == ST_LATCHED && all_clear
			|=> r.out.zone_green == ZONE_ALL && r.out.status == LAMP_RED && !r.out.safety_switching_outputs)
		else $error("Latched clear indication wrong");

	// Power-up status and zone lamps flash in step
	AST_FLASH_PHASE: assert property (@(posedge MCLK_I) disable iff (RESET_I)
		r.st == ST_PWRUP |=> (r.out.status == LAMP_RED) == (r.out.zone_red == ZONE_ALL))
		else $error("Power-up lamps out of phase");

endmodule
`default_nettype wire

// ==== lsr_pkg.sv ====
`default_nettype none
package lsr_pkg;

	// Geometry
	localparam int ZONES      = 8;
	localparam int DIV_W      = 23;
	localparam int STEP_W     = 3;
	localparam int PWR_W      = 5;
	localparam int SHOW_W     = 4;

	// Flash timing: one step of the common flash sequence
	localparam int CLK_PERIOD_NS = 40;
	localparam int FLASH_STEP_NS = 160_000_000;
	localparam logic [DIV_W-1:0] FLASH_STEP_CYC_DEF = DIV_W'(FLASH_STEP_NS / CLK_PERIOD_NS);

	// Sequence lengths counted in flash steps (one frame is eight steps)
	localparam logic [PWR_W-1:0]  SCAN_REPEATS   = 5'h03;
	localparam logic [PWR_W-1:0]  PWRUP_STEPS    = 5'h18;
	localparam logic [SHOW_W-1:0] SCAN_SHOW_STEPS = 4'h8;

	// Display codes
	localparam logic [7:0] CODE_SYNC_TRIP  = 8'h83;
	localparam logic [7:0] CODE_SYNC_LATCH = 8'h84;

	// Zone masks
	localparam logic [ZONES-1:0] ZONE_NONE  = 8'h00;
	localparam logic [ZONES-1:0] ZONE_ALL   = 8'hFF;
	localparam logic [ZONES-1:0] ZONE_FIRST = 8'h01;

	// Status lamp colours {red, green}
	localparam logic [1:0] LAMP_OFF   = 2'h0;
	localparam logic [1:0] LAMP_GREEN = 2'h1;
	localparam logic [1:0] LAMP_RED   = 2'h2;

	// Operating states
	typedef enum logic [2:0] {
		ST_PWRUP,
		ST_ALIGN,
		ST_RUN,
		ST_LATCHED,
		ST_LOCKOUT
	} lsr_state_t;

	// What the seven-segment display presents
	typedef enum logic [2:0] {
		DISP_BLANK,
		DISP_SCAN,
		DISP_TRIP,
		DISP_LATCH,
		DISP_COUNT,
		DISP_SYNC,
		DISP_FAULT
	} lsr_disp_t;

	// Beam results from the scanner
	typedef struct packed {
		logic             beam1_blocked;
		logic [ZONES-1:0] zone_blocked;
		logic [7:0]       blocked_count;
	} lsr_beams_t;

	// Configuration pins, cascade stop included
	typedef struct packed {
		logic latch_cfg;
		logic red_res;
		logic scan_code;
		logic cascade_stop_input;
	} lsr_cfg_t;

	// All indicator and output drive
	typedef struct packed {
		logic             safety_switching_outputs;
		logic [1:0]       status;
		logic             reset_lamp;
		logic [ZONES-1:0] zone_red;
		logic [ZONES-1:0] zone_green;
		lsr_disp_t        disp;
		logic [7:0]       disp_value;
		logic             posts;
	} lsr_lamps_t;

endpackage
`default_nettype wire

// ==== lsr_sync2.sv ====
`default_nettype none
module lsr_sync2
	import lsr_pkg::*;
#(
	parameter int W = 4
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Data
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} lsr_sync_t;

	lsr_sync_t r;
	lsr_sync_t next_r;

	// Two stages; only the second stage is read
	always_comb begin
		next_r.s1 = d_i;
		next_r.s2 = r.s1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign q_o = r.s2;

endmodule
`default_nettype wire

// ==== lsr_upstream.sv ====
`default_nettype none
module lsr_upstream (
	// Clock
	input  wire logic clk_i,
	// Upstream screen condition chosen by the bench
	input  wire logic blocked_i,
	// Stop level towards the downstream receiver
	output var logic  stop_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// Upstream screen answers a block with a registered stop level
	always_ff @(posedge clk_i) begin
		stop_o <= blocked_i;
	end
endmodule
`default_nettype wire

// ==== test_light_screen_receiver_indicator_logic.sv ====
`default_nettype none
module test_light_screen_receiver_indicator_logic
	import lsr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// Short flash step keeps the power-up sequence at 96 cycles
	localparam logic [DIV_W-1:0] STEP = 23'h00_0004;

	logic       MCLK_I  = 1'b0;
	logic       RESET_I = 1'b1;
	lsr_cfg_t   cfg     = '0;
	lsr_cfg_t   pins;
	lsr_beams_t beams   = '{1'b1, 8'h01, 8'h01};
	logic       lockout = 1'b0;
	logic       rreq    = 1'b0;
	logic       up_blk  = 1'b0;
	logic       up_stop;
	logic [7:0] fault   = 8'h00;
	lsr_lamps_t LAMPS_O;
	lsr_state_t STATE_O;
	int         n_errors  = 0;
	int         tests_run = 0;
	logic       s_grn, s_red, s_off, r_on, r_off, d_scan;

	// Clock and pin assembly
	always #20 MCLK_I = ~MCLK_I;
	assign pins = '{cfg.latch_cfg, cfg.red_res, cfg.scan_code, up_stop};

	lsr_upstream lsr_upstream_i (
		.clk_i    (MCLK_I),
		.blocked_i(up_blk),
		.stop_o   (up_stop)
	);

	lsr_indicator #(.FLASH_STEP_CYC(STEP)) lsr_indicator_i (
		.MCLK_I      (MCLK_I),
		.RESET_I     (RESET_I),
		.CFG_PINS_I  (pins),
		.BEAMS_I     (beams),
		.LOCKOUT_I   (lockout),
		.FAULT_CODE_I(fault),
		.RESET_REQ_I (rreq),
		.LAMPS_O     (LAMPS_O),
		.STATE_O     (STATE_O)
	);

	// Verdict and end of run
	task automatic test_done();
		if (n_errors == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input bit ok, input string msg);
		tests_run++;
		if (!ok) begin
			n_errors++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask

	// Waits n edges, then settles at the falling edge before any read
	task automatic tick(input int n);
		repeat (n) @(posedge MCLK_I);
		@(negedge MCLK_I);
	endtask

	task automatic set_beams(input logic b1, input logic [7:0] z, input logic [7:0] c);
		@(posedge MCLK_I);
		beams <= '{b1, z, c};
		tick(6);
	endtask

	task automatic pulse_req();
		@(posedge MCLK_I);
		rreq <= 1'b1;
		@(posedge MCLK_I);
		rreq <= 1'b0;
		tick(4);
	endtask

	// Records which lamp levels appear over a number of cycles
	task automatic watch(input int n);
		{s_grn, s_red, s_off, r_on, r_off, d_scan} = '0;
		repeat (n) begin
			@(negedge MCLK_I);
			s_grn |= LAMPS_O.status === LAMP_GREEN;
			s_red |= LAMPS_O.status === LAMP_RED;
			s_off |= LAMPS_O.status === LAMP_OFF;
			r_on |= LAMPS_O.reset_lamp === 1'b1;
			r_off |= LAMPS_O.reset_lamp === 1'b0;
			d_scan |= LAMPS_O.disp === DISP_SCAN;
		end
	endtask

	task automatic wait_state(input lsr_state_t st, input string msg);
		int i;
		for (i = 0; i < 300 && STATE_O !== st; i++) @(negedge MCLK_I);
		chk(STATE_O === st, msg);
		tick(2);
	endtask

	// Power-up flashing, then alignment with the first beam blocked
	task automatic t_pwrup();
		watch(32);
		chk(STATE_O === ST_PWRUP && s_red && s_off && !r_on, "power-up lamps");
		chk(d_scan && LAMPS_O.safety_switching_outputs === 1'b0, "power-up scan");
		wait_state(ST_ALIGN, "no align");
		chk(LAMPS_O.zone_red === ZONE_FIRST && LAMPS_O.zone_green === ZONE_NONE, "sync zones");
		chk(LAMPS_O.disp === DISP_SYNC && LAMPS_O.disp_value === CODE_SYNC_TRIP, "sync trip");
	endtask

	// Trip run, block and automatic recovery
	task automatic t_trip();
		set_beams(1'b0, 8'h00, 8'h00);
		wait_state(ST_RUN, "no trip run");
		chk(LAMPS_O.safety_switching_outputs === 1'b1 && LAMPS_O.status === LAMP_GREEN, "run");
		chk(LAMPS_O.reset_lamp === 1'b1 && LAMPS_O.zone_green === ZONE_ALL, "run lamps");
		chk(LAMPS_O.disp === DISP_TRIP, "trip shown");
		set_beams(1'b0, 8'h04, 8'h03);
		chk(LAMPS_O.safety_switching_outputs === 1'b0 && LAMPS_O.status === LAMP_RED, "blocked");
		chk(LAMPS_O.zone_red === 8'h04 && LAMPS_O.zone_green === 8'hFB, "zones");
		chk(LAMPS_O.disp === DISP_COUNT && LAMPS_O.disp_value === 8'h03, "count");
		set_beams(1'b0, 8'h00, 8'h00);
		chk(LAMPS_O.safety_switching_outputs === 1'b1, "no auto resume");
	endtask

	// Reduced resolution flash and a scan code change
	task automatic t_flash();
		@(posedge MCLK_I);
		cfg.red_res <= 1'b1;
		tick(6);
		watch(32);
		chk(s_grn && s_off && !s_red, "reduced resolution flash");
		@(posedge MCLK_I);
		cfg.red_res <= 1'b0;
		cfg.scan_code <= 1'b1;
		watch(12);
		chk(d_scan, "scan change unseen");
		tick(40);
		chk(LAMPS_O.disp === DISP_TRIP && LAMPS_O.status === LAMP_GREEN, "scan show stuck");
	endtask

	// Upstream stop brackets the display and drops the outputs
	task automatic t_cascade();
		@(posedge MCLK_I);
		up_blk <= 1'b1;
		tick(6);
		chk(LAMPS_O.posts === 1'b1 && LAMPS_O.safety_switching_outputs === 1'b0, "stop");
		chk(LAMPS_O.status === LAMP_RED && LAMPS_O.reset_lamp === 1'b1, "stop lamps");
		@(posedge MCLK_I);
		up_blk <= 1'b0;
		tick(6);
		chk(LAMPS_O.posts === 1'b0 && LAMPS_O.safety_switching_outputs === 1'b1, "stop held");
	endtask

	// Lockout overrides run; reset refused until the fault is gone
	task automatic t_lockout();
		@(posedge MCLK_I);
		lockout <= 1'b1;
		fault   <= 8'h5A;
		tick(3);
		watch(32);
		chk(STATE_O === ST_LOCKOUT && s_red && s_off && !s_grn && !r_on, "lockout lamps");
		chk(LAMPS_O.zone_red === ZONE_NONE && LAMPS_O.zone_green === ZONE_NONE, "zones lit");
		chk(LAMPS_O.disp === DISP_FAULT && LAMPS_O.disp_value === 8'h5A, "fault code");
		set_beams(1'b0, 8'h02, 8'h01);
		pulse_req();
		chk(STATE_O === ST_LOCKOUT && LAMPS_O.safety_switching_outputs === 1'b0, "left early");
		@(posedge MCLK_I);
		lockout <= 1'b0;
		pulse_req();
		chk(STATE_O === ST_ALIGN && LAMPS_O.reset_lamp === 1'b0, "no align");
	endtask

	// Latch mode: wait for reset, latch on block, resume on reset
	task automatic t_latch();
		@(posedge MCLK_I);
		cfg.latch_cfg <= 1'b1;
		tick(6);
		set_beams(1'b0, 8'h00, 8'h00);
		watch(32);
		chk(STATE_O === ST_ALIGN && r_on && r_off && s_red && !s_grn, "await reset");
		chk(LAMPS_O.disp === DISP_BLANK && LAMPS_O.zone_green === ZONE_ALL, "align clear");
		pulse_req();
		chk(LAMPS_O.safety_switching_outputs === 1'b1 && LAMPS_O.disp === DISP_LATCH, "latch run");
		set_beams(1'b1, 8'h01, 8'h01);
		chk(STATE_O === ST_LATCHED && LAMPS_O.disp_value === CODE_SYNC_LATCH, "latched");
		set_beams(1'b0, 8'h00, 8'h00);
		watch(32);
		chk(STATE_O === ST_LATCHED && r_on && r_off && !s_grn, "auto resume");
		chk(LAMPS_O.zone_green === ZONE_ALL, "latched zones");
		pulse_req();
		chk(LAMPS_O.safety_switching_outputs === 1'b1, "no resume");
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge MCLK_I);
		RESET_I <= 1'b0;
		@(posedge MCLK_I);
		t_pwrup();
		t_trip();
		t_flash();
		t_cascade();
		t_lockout();
		t_latch();
		test_done();
	end

	// Cuts a hung run short
	initial begin
		repeat (20000) @(posedge MCLK_I);
		n_errors++;
		test_done();
	end
endmodule
`default_nettype wire
